// ===== src/pbc_pkg.sv
// Constants, codes, states and decode helpers for the bridge command block.
package pbc_pkg;
  localparam logic [15:0] OFS_CTRL     = 16'h0000;
  localparam logic [15:0] OFS_STAT     = 16'h0004;
  localparam logic [15:0] OFS_CFG_ADDR = 16'h0008;
  localparam logic [15:0] OFS_CFG_DATA = 16'h000c;
  localparam logic [15:0] OFS_INTACK   = 16'h0010;
  localparam logic [15:0] OFS_SPC      = 16'h0014;
  localparam logic [15:0] OFS_MIR_LO   = 16'hd000;
  localparam logic [15:0] OFS_MIR_HI   = 16'hd07f;
  localparam int          MIR_WORDS    = 32;
  localparam int          MIR_IDX_LSB  = 2;
  localparam int          MIR_IDX_W    = 5;

  localparam int          CTRL_CLS_LSB   = 0;
  localparam int          CTRL_CLS_W     = 8;
  localparam int          CTRL_MWI_BIT   = 8;
  localparam int          CTRL_IRBER_BIT = 9;
  localparam int          CTRL_TCAR_BIT  = 10;
  localparam int          CTRL_W         = 11;
  localparam logic [10:0] CTRL_RST       = 11'h200;

  localparam int          STAT_HOST_BIT  = 0;
  localparam int          STAT_BUSY_BIT  = 1;
  localparam int          STAT_TCMD_LSB  = 4;

  localparam int          CFG_BUS_LSB    = 16;
  localparam int          CFG_BUS_W      = 8;
  localparam logic [1:0]  CFG_TYPE0      = 2'h0;
  localparam logic [1:0]  CFG_TYPE1      = 2'h1;
  localparam logic [31:0] ALL_ONES       = 32'hffff_ffff;
  localparam logic [3:0]  BE_ALL         = 4'hf;

  localparam logic [3:0] CMD_INTACK = 4'h0;
  localparam logic [3:0] CMD_SPC    = 4'h1;
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_RSV4   = 4'h4;
  localparam logic [3:0] CMD_RSV5   = 4'h5;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_RSV8   = 4'h8;
  localparam logic [3:0] CMD_RSV9   = 4'h9;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MRM    = 4'hc;
  localparam logic [3:0] CMD_DAC    = 4'hd;
  localparam logic [3:0] CMD_MRL    = 4'he;
  localparam logic [3:0] CMD_MWI    = 4'hf;

  localparam logic [1:0] ACT_NONE  = 2'h0;
  localparam logic [1:0] ACT_CLAIM = 2'h1;
  localparam logic [1:0] ACT_RETRY = 2'h2;

  typedef enum logic [1:0] {I_IDLE = 2'b00, I_REQ = 2'b01, I_REL = 2'b10} pbc_ist_e;
  typedef enum logic       {T_ADDR = 1'b0, T_DAC = 1'b1} pbc_tst_e;

  function automatic logic pbc_is_rsvd(input logic [3:0] c);
    return (c == CMD_RSV4) || (c == CMD_RSV5) || (c == CMD_RSV8) || (c == CMD_RSV9);
  endfunction

  function automatic logic pbc_is_cfg(input logic [3:0] c);
    return (c == CMD_CFG_RD) || (c == CMD_CFG_WR);
  endfunction

  // Falls back to plain write or plain read whenever a condition is missing.
  function automatic logic [3:0] pbc_pick_cmd(input logic       wr,
                                              input logic       io,
                                              input logic       burst,
                                              input logic [7:0] words,
                                              input logic [7:0] cls,
                                              input logic       mwi,
                                              input logic       line);
    if (io) return wr ? CMD_IO_WR : CMD_IO_RD;
    if (wr) return (mwi && (cls != 8'h00) && (words >= cls)) ? CMD_MWI : CMD_MEM_WR;
    if (burst && (cls != 8'h00) && (words <= cls)) return line ? CMD_MRL : CMD_MRM;
    return CMD_MEM_RD;
  endfunction

  function automatic logic [1:0] pbc_tgt_act(input logic [3:0] c,
                                             input logic       host,
                                             input logic       tcar);
    case (c)
      CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_MRM, CMD_MRL, CMD_MWI: return ACT_CLAIM;
      CMD_CFG_RD, CMD_CFG_WR: return host ? ACT_NONE : (tcar ? ACT_CLAIM : ACT_RETRY);
      default: return ACT_NONE;
    endcase
  endfunction
endpackage

// ===== src/pbc_cmd.sv
// Command selection, mode strap and register front end of the PCI bridge.
//
// Summary of operation
// - Strap pin high at reset release selects host.
// - Config space reachable from PCI only in satellite.
// - Control registers answer the core only, never PCI.
// - Mirror range D000-D07F works only in host.
// - I/O, memory, DAC, burst commands both directions.
// - Intack, special, config issued only as host.
// - Config commands claimed as target only in satellite.
// - Burst reads enable all bytes; singles as needed.
// - Burst read uses read multiple within line size.
// - Read line chosen by parameter instead of multiple.
// - Zero line size gives plain memory read.
// - Target read multiple/line become plain internal cycles.
// - Write invalidate needs enable, size, enough words.
// - Otherwise plain memory write is issued.
// - Target write invalidate becomes plain write, no snoop.
// - Address above 32 bits uses dual address cycle.
// - Target accepts dual address then plain internal cycle.
// - Config data access after address issues config cycle.
// - Unanswered config read errors, or reads all ones.
// - Target retries config until ready bit set.
// - Intack register read runs intack, returns data.
// - Special register write drives special cycle data.
// - PCI side asynchronous; every pin synchronised first.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module pbc_cmd
  import pbc_pkg::*;
#(
  parameter int unsigned USE_READ_LINE = 0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        strap_addr19,
  input  wire logic        greq_valid,
  input  wire logic        greq_write,
  input  wire logic        greq_io,
  input  wire logic        greq_burst,
  input  wire logic [7:0]  greq_words,
  input  wire logic [39:0] greq_addr,
  input  wire logic [3:0]  greq_be,
  input  wire logic [31:0] greq_wdata,
  output logic             greq_ready,
  output logic             ini_valid,
  output logic [3:0]       ini_cmd,
  output logic             ini_dac,
  output logic [39:0]      ini_addr,
  output logic [3:0]       ini_be,
  output logic [31:0]      ini_wdata,
  input  wire logic        pci_ack,
  input  wire logic        pci_noresp,
  input  wire logic [31:0] pci_rdata,
  input  wire logic        pci_clk,
  input  wire logic        pci_frame_n,
  input  wire logic [3:0]  pci_cbe_n,
  output logic             tgt_claim,
  output logic             tgt_retry,
  output logic             tgt_gbus_valid,
  output logic             tgt_gbus_write,
  output logic [3:0]       tgt_cmd,
  output logic             host_mode
);
  if (USE_READ_LINE > 1) begin : g_chk
    $error("USE_READ_LINE must be 0 or 1");
  end

  typedef struct packed {
    logic                              strap_m;
    logic                              strap_s;
    logic [1:0]                        strap_v;
    logic                              strap_done;
    logic                              host;
    logic [CTRL_W-1:0]                 ctrl;
    logic [31:0]                       cfg_addr;
    logic [31:0]                       spc_data;
    logic [MIR_WORDS-1:0][31:0]        mir;
    logic                              pready;
    logic [31:0]                       prdata;
    logic                              pslverr;
    pbc_ist_e                          ist;
    logic                              src_apb;
    logic                              src_rd;
    logic                              greq_ready;
    logic                              ini_valid;
    logic [3:0]                        ini_cmd;
    logic                              ini_dac;
    logic [39:0]                       ini_addr;
    logic [3:0]                        ini_be;
    logic [31:0]                       ini_wdata;
    logic                              ack_m;
    logic                              ack_s;
    logic                              nores_m;
    logic                              nores_s;
    logic [31:0]                       rdat_m;
    logic [31:0]                       rdat_s;
    logic                              pclk_m;
    logic                              pclk_s;
    logic                              pclk_p;
    logic                              frame_m;
    logic                              frame_s;
    logic                              frame_q;
    logic [3:0]                        cbe_m;
    logic [3:0]                        cbe_s;
    pbc_tst_e                          tst;
    logic                              tgt_claim;
    logic                              tgt_retry;
    logic                              tgt_gbus_valid;
    logic                              tgt_gbus_write;
    logic [3:0]                        tgt_cmd;
  } pbc_state_s;

  pbc_state_s r;
  pbc_state_s n;

  logic       acc;
  logic       mir_hit;
  logic       pci_go;
  logic       apb_go;
  logic       greq_take;
  logic       pclk_rise;
  logic       tgt_start;
  logic [7:0] cls;
  logic [3:0] tc;
  logic [1:0] act;
  logic       decide;

  always_comb begin
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.tgt_claim = 1'b0;
    n.tgt_retry = 1'b0;
    n.tgt_gbus_valid = 1'b0;
    cls = r.ctrl[CTRL_CLS_LSB +: CTRL_CLS_W];

    // Every pin from the PCI side passes two flip-flops first.
    n.strap_m = strap_addr19;
    n.strap_s = r.strap_m;
    n.ack_m = pci_ack;
    n.ack_s = r.ack_m;
    n.nores_m = pci_noresp;
    n.nores_s = r.nores_m;
    n.rdat_m = pci_rdata;
    n.rdat_s = r.rdat_m;
    n.pclk_m = pci_clk;
    n.pclk_s = r.pclk_m;
    n.pclk_p = r.pclk_s;
    n.frame_m = pci_frame_n;
    n.frame_s = r.frame_m;
    n.cbe_m = pci_cbe_n;
    n.cbe_s = r.cbe_m;

    // The strap is caught once, after its synchroniser has filled.
    n.strap_v = {r.strap_v[0], 1'b1};
    if (r.strap_v[1] && !r.strap_done) begin
      n.strap_done = 1'b1;
      n.host = r.strap_s;
    end

    acc = psel && penable && !r.pready;
    mir_hit = (paddr >= OFS_MIR_LO) && (paddr <= OFS_MIR_HI);
    pci_go = (paddr == OFS_CFG_DATA) || ((paddr == OFS_INTACK) && !pwrite) ||
             ((paddr == OFS_SPC) && pwrite);
    greq_take = greq_valid && r.greq_ready && (r.ist == I_IDLE);
    apb_go = acc && pci_go && r.host && (r.ist == I_IDLE) && !greq_take;

    // Register answers that need no PCI cycle raise pready one cycle after penable rises.
    if (acc && !(pci_go && r.host)) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      if (pci_go) begin
        n.pslverr = 1'b1;
      end else if (mir_hit) begin
        if (r.host) begin
          if (pwrite) begin
            n.mir[paddr[MIR_IDX_LSB +: MIR_IDX_W]] = pwdata;
          end else begin
            n.prdata = r.mir[paddr[MIR_IDX_LSB +: MIR_IDX_W]];
          end
        end else begin
          n.pslverr = 1'b1;
        end
      end else begin
        case (paddr)
          OFS_CTRL: begin
            if (pwrite) begin
              n.ctrl = pwdata[CTRL_W-1:0];
            end
            n.prdata = {{(32 - CTRL_W){1'b0}}, r.ctrl};
          end
          OFS_STAT: begin
            n.prdata[STAT_HOST_BIT] = r.host;
            n.prdata[STAT_BUSY_BIT] = (r.ist != I_IDLE);
            n.prdata[STAT_TCMD_LSB +: 4] = r.tgt_cmd;
          end
          OFS_CFG_ADDR: begin
            if (pwrite) begin
              n.cfg_addr = pwdata;
            end
            n.prdata = r.cfg_addr;
          end
          OFS_SPC: n.prdata = r.spc_data;
          default: n.pslverr = 1'b1;
        endcase
      end
    end

    case (r.ist)
      I_IDLE: begin
        if (greq_take) begin
          n.ini_cmd = pbc_pick_cmd(greq_write, greq_io, greq_burst, greq_words, cls,
                                   r.ctrl[CTRL_MWI_BIT], USE_READ_LINE[0]);
          n.ini_be = (greq_burst && !greq_write && !greq_io) ? BE_ALL : greq_be;
          n.ini_addr = greq_addr;
          n.ini_dac = (greq_addr[39:32] != 8'h00);
          n.ini_wdata = greq_wdata;
          n.src_apb = 1'b0;
          n.src_rd = !greq_write;
          n.ini_valid = 1'b1;
          n.ist = I_REQ;
        end else if (apb_go) begin
          n.src_apb = 1'b1;
          n.src_rd = !pwrite;
          n.ini_be = BE_ALL;
          n.ini_dac = 1'b0;
          n.ini_addr = 40'h00_0000_0000;
          n.ini_wdata = pwdata;
          n.ini_valid = 1'b1;
          n.ist = I_REQ;
          if (paddr == OFS_CFG_DATA) begin
            n.ini_cmd = pwrite ? CMD_CFG_WR : CMD_CFG_RD;
            n.ini_addr[31:0] = {r.cfg_addr[31:2], (r.cfg_addr[CFG_BUS_LSB +: CFG_BUS_W] == 8'h00)
                                ? CFG_TYPE0 : CFG_TYPE1};
          end else if (paddr == OFS_INTACK) begin
            n.ini_cmd = CMD_INTACK;
          end else begin
            n.ini_cmd = CMD_SPC;
            n.spc_data = pwdata;
          end
        end
      end
      I_REQ: begin
        if (r.ack_s) begin
          n.ini_valid = 1'b0;
          n.ist = I_REL;
          if (r.src_apb) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            if (r.src_rd) begin
              if (r.nores_s) begin
                n.pslverr = r.ctrl[CTRL_IRBER_BIT];
                n.prdata = r.ctrl[CTRL_IRBER_BIT] ? 32'h0000_0000 : ALL_ONES;
              end else begin
                n.prdata = r.rdat_s;
              end
            end
          end
        end
      end
      I_REL: begin
        if (!r.ack_s) begin
          n.ist = I_IDLE;
        end
      end
      default: n.ist = I_IDLE;
    endcase
    n.greq_ready = (n.ist == I_IDLE) && !apb_go;

    // Target decode runs on edges of the sampled PCI clock; no path reaches the
    // control registers from here.
    pclk_rise = r.pclk_s && !r.pclk_p;
    tgt_start = pclk_rise && !r.frame_s && r.frame_q;
    if (pclk_rise) begin
      n.frame_q = r.frame_s;
    end
    tc = r.cbe_s;
    decide = 1'b0;
    case (r.tst)
      T_ADDR: begin
        if (tgt_start) begin
          if (tc == CMD_DAC) begin
            n.tst = T_DAC;
          end else begin
            decide = 1'b1;
          end
        end
      end
      T_DAC: begin
        if (pclk_rise) begin
          decide = 1'b1;
          n.tst = T_ADDR;
        end
      end
      default: n.tst = T_ADDR;
    endcase
    act = pbc_tgt_act(tc, r.host, r.ctrl[CTRL_TCAR_BIT]);
    if (decide) begin
      n.tgt_cmd = tc;
      n.tgt_claim = (act == ACT_CLAIM);
      n.tgt_retry = (act == ACT_RETRY);
      // Read line, read multiple and write invalidate all become plain cycles.
      n.tgt_gbus_valid = (act == ACT_CLAIM) && !pbc_is_cfg(tc);
      n.tgt_gbus_write = tc[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.ist <= I_IDLE;
      r.tst <= T_ADDR;
      r.frame_m <= 1'b1;
      r.frame_s <= 1'b1;
      r.frame_q <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign greq_ready = r.greq_ready;
  assign ini_valid = r.ini_valid;
  assign ini_cmd = r.ini_cmd;
  assign ini_dac = r.ini_dac;
  assign ini_addr = r.ini_addr;
  assign ini_be = r.ini_be;
  assign ini_wdata = r.ini_wdata;
  assign tgt_claim = r.tgt_claim;
  assign tgt_retry = r.tgt_retry;
  assign tgt_gbus_valid = r.tgt_gbus_valid;
  assign tgt_gbus_write = r.tgt_gbus_write;
  assign tgt_cmd = r.tgt_cmd;
  assign host_mode = r.host;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_acc_s;
    psel && penable && !r.pready;
  endsequence

  sequence cfg_miss_s;
    (r.ist == I_REQ) && r.src_apb && r.src_rd && r.ack_s && r.nores_s;
  endsequence

  strap_mode_a: assert property ($rose(r.strap_done) |-> r.host == $past(r.strap_s))
    else $error("mode differs from strap");
  host_cmd_only_a: assert property (r.ini_valid && (pbc_is_cfg(r.ini_cmd) ||
    r.ini_cmd == CMD_INTACK || r.ini_cmd == CMD_SPC) |-> r.host)
    else $error("host-only command issued in satellite mode");
  ctrl_isolated_a: assert property ($changed(r.ctrl) |-> $past(psel && penable &&
    pwrite && paddr == OFS_CTRL))
    else $error("control register changed without core write");
  mirror_block_a: assert property (apb_acc_s ##0 (paddr >= OFS_MIR_LO &&
    paddr <= OFS_MIR_HI && !r.host) |=> pready && pslverr)
    else $error("mirror register reachable in satellite mode");
  tgt_plain_a: assert property (tgt_claim && !pbc_is_cfg(tgt_cmd) |-> tgt_gbus_valid)
    else $error("claimed command made no internal cycle");
  rsvd_cmd_a: assert property ((ini_valid |-> !pbc_is_rsvd(ini_cmd)) and
    (tgt_claim |-> !pbc_is_rsvd(tgt_cmd)))
    else $error("reserved command used");
  tgt_no_special_a: assert property (tgt_claim |-> tgt_cmd != CMD_INTACK &&
    tgt_cmd != CMD_SPC && !(pbc_is_cfg(tgt_cmd) && r.host))
    else $error("unsupported target command claimed");
  burst_be_a: assert property ($rose(ini_valid) && (ini_cmd == CMD_MRM ||
    ini_cmd == CMD_MRL) |-> ini_be == BE_ALL)
    else $error("burst read without all byte enables");
  line_read_a: assert property ($rose(ini_valid) && (ini_cmd == CMD_MRM ||
    ini_cmd == CMD_MRL) |-> r.ctrl[CTRL_CLS_LSB +: CTRL_CLS_W] != 8'h00)
    else $error("line read with zero line size");
  mwi_cond_a: assert property ($rose(ini_valid) && ini_cmd == CMD_MWI |->
    r.ctrl[CTRL_MWI_BIT] && r.ctrl[CTRL_CLS_LSB +: CTRL_CLS_W] != 8'h00)
    else $error("write invalidate without its conditions");
  dac_a: assert property ($rose(ini_valid) |-> ini_dac == (ini_addr[39:32] != 8'h00))
    else $error("dual address cycle choice wrong");
  cfg_miss_a: assert property (cfg_miss_s |=> pready &&
    (pslverr == $past(r.ctrl[CTRL_IRBER_BIT])) && (pslverr || prdata == ALL_ONES))
    else $error("unanswered config read handled wrongly");
  cfg_retry_a: assert property (tgt_retry |-> !r.ctrl[CTRL_TCAR_BIT] && !r.host &&
    pbc_is_cfg(tgt_cmd))
    else $error("retry outside config-not-ready window");
  pci_done_a: assert property ((r.ist == I_REQ) && r.src_apb && r.ack_s |=>
    pready ##1 !pready)
    else $error("PCI-backed register access did not complete");
endmodule

// ===== tb/pbc_pci_model.sv
// Behavioural far-side PCI agent that completes the bridge's initiator cycles.
`timescale 1ns/1ps
module pbc_pci_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ini_valid,
  input  wire logic        slow,
  input  wire logic        no_target,
  input  wire logic [31:0] answer,
  output logic             pci_ack,
  output logic             pci_noresp,
  output logic [31:0]      pci_rdata
);
  int wait_cnt;

  // Slow mode keeps the bridge waiting well past its synchroniser delay.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt = 0;
      pci_ack <= 1'b0;
      pci_noresp <= 1'b0;
      pci_rdata <= 32'h0;
    end else if (pci_ack && !ini_valid) begin
      pci_ack <= 1'b0;
      pci_noresp <= 1'b0;
      pci_rdata <= ~pci_rdata;
    end else if (ini_valid && !pci_ack) begin
      wait_cnt = wait_cnt + 1;
      if (wait_cnt > (slow ? 20 : 1)) begin
        wait_cnt = 0;
        pci_ack <= 1'b1;
        pci_noresp <= no_target;
        pci_rdata <= no_target ? ~answer : answer;
      end
    end
  end
endmodule

// ===== tb/pbc_cmd_tb.sv
// Self-checking bench for the bridge command block.
`timescale 1ns/1ps
module pbc_cmd_tb import pbc_pkg::*; ;
  typedef struct packed {
    logic        wr, io, bu;
    logic [7:0]  words, cls;
    logic        mwi;
    logic [39:0] addr;
    logic [3:0]  be, xcmd;
    logic        xdac;
    logic [3:0]  xbe;
  } pbc_row_s;
  localparam pbc_row_s ROWS [11] = '{
    '{1'b0,1'b1,1'b0,8'h01,8'h00,1'b0,40'h0000000100,4'h3,4'h2,1'b0,4'h3},
    '{1'b1,1'b1,1'b0,8'h01,8'h00,1'b0,40'h0000000104,4'hc,4'h3,1'b0,4'hc},
    '{1'b1,1'b0,1'b1,8'h08,8'h08,1'b1,40'h1000000000,4'hf,4'hf,1'b1,4'hf},
    '{1'b1,1'b0,1'b1,8'h07,8'h08,1'b1,40'h0000001000,4'hf,4'h7,1'b0,4'hf},
    '{1'b1,1'b0,1'b1,8'h10,8'h08,1'b0,40'h0000001000,4'hf,4'h7,1'b0,4'hf},
    '{1'b1,1'b0,1'b1,8'h10,8'h00,1'b1,40'h0000001000,4'hf,4'h7,1'b0,4'hf},
    '{1'b0,1'b0,1'b1,8'h08,8'h08,1'b0,40'h0000002000,4'h1,4'hc,1'b0,4'hf},
    '{1'b0,1'b0,1'b1,8'h09,8'h08,1'b0,40'h0000002000,4'h1,4'h6,1'b0,4'hf},
    '{1'b0,1'b0,1'b1,8'h04,8'h00,1'b0,40'h0000002000,4'h1,4'h6,1'b0,4'hf},
    '{1'b0,1'b0,1'b0,8'h01,8'h08,1'b0,40'h00fffffffc,4'h5,4'h6,1'b0,4'h5},
    '{1'b0,1'b0,1'b0,8'h01,8'h08,1'b0,40'h0100000000,4'h2,4'h6,1'b1,4'h2}};

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, strap_addr19;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, greq_wdata, ini_wdata, pci_rdata, answer, rd, cap_wd;
  logic        greq_valid, greq_write, greq_io, greq_burst, greq_ready, ini_valid, ini_dac;
  logic [7:0]  greq_words;
  logic [39:0] greq_addr, ini_addr, cap_addr;
  logic [3:0]  greq_be, ini_cmd, ini_be, pci_cbe_n, tgt_cmd, cap_cmd, cap_be;
  logic        pci_ack, pci_noresp, pci_clk, pci_frame_n, tgt_claim, tgt_retry;
  logic        tgt_gbus_valid, tgt_gbus_write, host_mode, slow, no_target, err, cap_dac;
  logic [2:0]  seen;
  int          mismatches, checks_done;

  pbc_cmd u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .strap_addr19, .greq_valid, .greq_write, .greq_io, .greq_burst,
    .greq_words, .greq_addr, .greq_be, .greq_wdata, .greq_ready, .ini_valid, .ini_cmd,
    .ini_dac, .ini_addr, .ini_be, .ini_wdata, .pci_ack, .pci_noresp, .pci_rdata, .pci_clk,
    .pci_frame_n, .pci_cbe_n, .tgt_claim, .tgt_retry, .tgt_gbus_valid, .tgt_gbus_write,
    .tgt_cmd, .host_mode);
  pbc_pci_model u_far (.pclk, .presetn, .ini_valid, .slow, .no_target, .answer, .pci_ack,
    .pci_noresp, .pci_rdata);

  always #5 pclk = ~pclk;

  // Initiator fields are captured while pending, target pulses are latched until cleared.
  always @(posedge pclk) begin
    if (ini_valid === 1'b1) begin
      {cap_cmd, cap_dac, cap_addr, cap_be, cap_wd} <= {ini_cmd, ini_dac, ini_addr, ini_be,
                                                       ini_wdata};
    end
    if (tgt_claim === 1'b1) seen[2] <= 1'b1;
    if (tgt_retry === 1'b1) seen[1] <= 1'b1;
    if (tgt_gbus_valid === 1'b1) seen[0] <= 1'b1;
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic send(input pbc_row_s r);
    apb(1'b1, OFS_CTRL, {23'h1, r.mwi, r.cls});
    {greq_write, greq_io, greq_burst} <= {r.wr, r.io, r.bu};
    {greq_words, greq_addr, greq_be} <= {r.words, r.addr, r.be};
    greq_valid <= 1'b1;
    @(posedge pclk);
    while (greq_ready !== 1'b1) @(posedge pclk);
    greq_valid <= 1'b0;
    greq_addr <= ~r.addr;
    @(posedge pclk);
    while (greq_ready !== 1'b1) @(posedge pclk);
  endtask

  task automatic edge_at(input logic fr, input logic [3:0] c);
    pci_frame_n <= fr;
    pci_cbe_n <= c;
    repeat (8) @(posedge pclk);
    pci_clk <= 1'b1;
    repeat (8) @(posedge pclk);
    pci_clk <= 1'b0;
  endtask

  function automatic logic [2:0] tgt_exp(input logic [3:0] c, input logic h, input logic r);
    if (c inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf}) return 3'b101;
    if (c inside {4'ha, 4'hb} && !h) return r ? 3'b100 : 3'b010;
    return 3'b000;
  endfunction

  task automatic sweep(input logic h, input logic r);
    logic [3:0] xc;
    for (int c = 0; c < 16; c++) begin
      seen = 3'b000;
      xc = (c == 13) ? 4'h6 : 4'(c);
      edge_at(1'b1, ~4'(c));
      edge_at(1'b0, 4'(c));
      if (c == 13) edge_at(1'b0, 4'h6);
      pci_frame_n <= 1'b1;
      pci_cbe_n <= ~4'(c);
      repeat (12) @(posedge pclk);
      chk(seen, tgt_exp(xc, h, r));
      chk({tgt_cmd, tgt_gbus_write}, {xc, xc[0]});
    end
    $display("done: target sweep");
  endtask

  task automatic do_reset(input logic strap);
    presetn <= 1'b0;
    strap_addr19 <= strap;
    repeat (12) @(posedge pclk);
    chk(host_mode, 1'b0);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(host_mode, strap);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0000_0200);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd[STAT_HOST_BIT], strap);
    $display("done: reset");
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, strap_addr19, slow} = '0;
    {greq_valid, greq_write, greq_io, greq_burst, greq_words, greq_addr, greq_be} = '0;
    {greq_wdata, pci_clk, pci_cbe_n, no_target, answer, seen} = '0;
    pci_frame_n = 1'b1;
    do_reset(1'b1);
    foreach (ROWS[i]) begin
      send(ROWS[i]);
      chk(cap_cmd, ROWS[i].xcmd);
      chk({cap_dac, cap_addr}, {ROWS[i].xdac, ROWS[i].addr});
      chk(cap_be, ROWS[i].xbe);
    end
    $display("done: command table");
    apb(1'b1, OFS_CTRL, 32'h0000_0200);
    apb(1'b1, OFS_CFG_ADDR, 32'h0001_0804);
    // The far side drives a value other than all ones, so only the bridge can make them.
    {no_target, answer} <= {1'b1, 32'h0000_00ff};
    apb(1'b0, OFS_CFG_DATA, 32'h0);
    chk({err, cap_cmd, cap_addr}, {1'b1, 4'ha, 40'h00_0001_0805});
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CFG_DATA, 32'h0);
    chk({err, rd}, {1'b0, 32'hffff_ffff});
    {no_target, slow, answer} <= {2'b01, 32'h1234_5678};
    apb(1'b1, OFS_CFG_ADDR, 32'h0000_0800);
    apb(1'b1, OFS_CFG_DATA, 32'hcafe_0001);
    chk({cap_cmd, cap_addr, cap_wd}, {4'hb, 40'h800, 32'hcafe_0001});
    apb(1'b0, OFS_INTACK, 32'h0);
    chk({err, cap_cmd, cap_be, rd}, {1'b0, 4'h0, 4'hf, 32'h1234_5678});
    apb(1'b1, OFS_SPC, 32'h0000_00a5);
    chk({cap_cmd, cap_be, cap_wd}, {4'h1, 4'hf, 32'h0000_00a5});
    apb(1'b1, OFS_INTACK, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 16'hd07c, 32'h5a5a_0f0f);
    apb(1'b0, 16'hd07c, 32'h0);
    chk({err, rd}, {1'b0, 32'h5a5a_0f0f});
    apb(1'b0, 16'h0020, 32'h0);
    chk(err, 1'b1);
    $display("done: host registers");
    sweep(1'b1, 1'b0);
    do_reset(1'b0);
    apb(1'b0, OFS_MIR_LO, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, OFS_CFG_DATA, 32'h0);
    chk(err, 1'b1);
    apb(1'b0, OFS_INTACK, 32'h0);
    chk(err, 1'b1);
    sweep(1'b0, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0000_0600);
    sweep(1'b0, 1'b1);
    wrap_up();
  end

  initial begin
    #400_000;
    mismatches++;
    wrap_up();
  end
endmodule
